// File: rtl/ctimer_pkg.sv
// package: register map, field layout and shared types of the compact timer
package ctimer_pkg;

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL_A = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL_B = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A_LOW = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A_HIGH = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_P_TOP = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_MATCH_STATUS = 3'h7;

  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_COMPARE_A = 16'h0000;
  localparam logic [7:0] RST_COMPARE_P = 8'h00;

  // match status bits, write one to clear
  localparam int STAT_A_BIT = 0;
  localparam int STAT_P_BIT = 1;

  // ----------------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A = 3'h4;
  localparam logic [2:0] CLK_SUB_B = 3'h5;
  localparam logic [2:0] CLK_PIN_RISE = 3'h6;
  localparam logic [2:0] CLK_PIN_FALL = 3'h7;

  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;

  localparam int CLK_PERIOD_NS = 50;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pause_control;
    logic [2:0] count_clock_select;
    logic counter_on;
    logic [2:0] unused;
  } control_a_t;

  typedef struct packed {
    mode_t mode_select;
    logic [1:0] pin_action_select;
    logic output_init_level;
    logic output_invert;
    logic duty_period_swap;
    logic clear_source_select;
  } control_b_t;

endpackage

// File: rtl/pin_edge_sync.sv
// two-stage synchroniser with rise and fall pulses for an external level
module pin_edge_sync
  import ctimer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic sync;
  logic last;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise_o = sync & ~last;
  assign fall_o = ~sync & last;

endmodule // pin_edge_sync

// File: rtl/compact_timer.sv
// compact 16-bit timer with comparators a and p, pwm and register port
//
// Notes on behaviour
// - three-bit field picks the count clock source
// - counter_on rising clears the counter
// - counter_on low stops and holds the count
// - counter_on rising reloads pin initial level
// - low three control-a bits read zero
// - mode field: compare, undefined, pwm, timer
// - compare mode pin action on a match
// - pwm pin action: inactive, active, wave
// - action equal to initial level shows nothing
// - init level sets start level or polarity
// - invert control flips the output pin in compare and pwm modes
// - swap chooses period and duty comparators
// - clear source picks a or p match
// - pwm mode ignores the clear source
// - counter readable as two read-only bytes
// - compare a held as two writable bytes
// - compare p matches counter top byte
// - compare p zero lets counter overflow
// - pause holds count, resumes from it
// - low bytes pass through shared byte buffer
// - a and p flags set on matches; p only with clear source p or in pwm mode
module compact_timer
  import ctimer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire reg_req_t bus_req_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic external_count_pin_i,
  input wire logic sub_clock_i,
  output logic timer_output_pin_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  control_a_t ctrl_a;
  control_b_t ctrl_b;
  logic [15:0] count;
  logic [15:0] compare_a_value;
  logic [7:0] compare_p_value;
  logic [7:0] byte_buffer;
  logic compare_a_flag;
  logic compare_p_flag;
  logic [5:0] prescale;
  logic on_last;
  logic pin_level;

  logic pin_rise;
  logic pin_fall;
  logic sub_rise;
  logic count_tick;
  logic running;
  logic on_rise;
  logic [16:0] count_inc;
  logic a_match;
  logic p_match;
  logic overflow;
  logic clear_now;
  logic a_event;
  logic p_event;
  logic pwm_active;
  logic next_pin_level;
  logic wr_a;
  logic wr_b;
  logic clr_a_flag;
  logic clr_p_flag;

  // ----------------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------------
  // the high clock is taken as the system clock; the sub clock and the
  // external pin are slow levels sampled here, so counting stays in one
  // domain at the cost of losing edges faster than half the system clock
  pin_edge_sync u_ext_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(external_count_pin_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  pin_edge_sync u_sub_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(sub_clock_i),
    .rise_o(sub_rise),
    .fall_o()
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      prescale <= 6'h00;
    else
      prescale <= prescale + 6'h01;
  end

  always_comb
  begin
    unique case (ctrl_a.count_clock_select)
      CLK_SYS_DIV4: count_tick = (prescale & DIV4_MASK) == DIV4_MASK;
      CLK_SYS: count_tick = 1'b1;
      CLK_HIGH_DIV16: count_tick = (prescale & DIV16_MASK) == DIV16_MASK;
      CLK_HIGH_DIV64: count_tick = (prescale & DIV64_MASK) == DIV64_MASK;
      CLK_SUB_A, CLK_SUB_B: count_tick = sub_rise;
      CLK_PIN_RISE: count_tick = pin_rise;
      CLK_PIN_FALL: count_tick = pin_fall;
    endcase
  end

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  assign wr_a = bus_req_i.wr && bus_req_i.addr == OFS_TIMER_CONTROL_A;
  assign wr_b = bus_req_i.wr && bus_req_i.addr == OFS_TIMER_CONTROL_B;
  assign clr_a_flag = bus_req_i.wr && bus_req_i.addr == OFS_MATCH_STATUS
                      && bus_req_i.wdata[STAT_A_BIT];
  assign clr_p_flag = bus_req_i.wr && bus_req_i.addr == OFS_MATCH_STATUS
                      && bus_req_i.wdata[STAT_P_BIT];

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_a <= control_a_t'(RST_CONTROL_A);
      ctrl_b <= control_b_t'(RST_CONTROL_B);
    end
    else
    begin
      if (wr_a)
        ctrl_a <= control_a_t'({bus_req_i.wdata[7:3], 3'h0});
      // mode and pin action are taken as written; changing them while
      // running is the software's hazard
      if (wr_b)
        ctrl_b <= control_b_t'(bus_req_i.wdata);
    end
  end

  // compare registers and the shared low-byte buffer
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_a_value <= RST_COMPARE_A;
      compare_p_value <= RST_COMPARE_P;
      byte_buffer <= 8'h00;
    end
    else if (bus_req_i.wr)
    begin
      unique case (bus_req_i.addr)
        OFS_COMPARE_A_LOW: byte_buffer <= bus_req_i.wdata;
        OFS_COMPARE_A_HIGH:
          compare_a_value <= {bus_req_i.wdata, byte_buffer};
        OFS_COMPARE_P_TOP: compare_p_value <= bus_req_i.wdata;
        default: ;
      endcase
    end
    else if (bus_req_i.rd)
    begin
      unique case (bus_req_i.addr)
        OFS_COUNT_HIGH: byte_buffer <= count[7:0];
        OFS_COMPARE_A_HIGH: byte_buffer <= compare_a_value[7:0];
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else if (!bus_req_i.rd)
      rdata_o <= 8'h00;
    else
    begin
      unique case (bus_req_i.addr)
        OFS_TIMER_CONTROL_A: rdata_o <= {ctrl_a[7:3], 3'h0};
        OFS_TIMER_CONTROL_B: rdata_o <= ctrl_b;
        OFS_COUNT_LOW: rdata_o <= byte_buffer;
        OFS_COUNT_HIGH: rdata_o <= count[15:8];
        OFS_COMPARE_A_LOW: rdata_o <= byte_buffer;
        OFS_COMPARE_A_HIGH: rdata_o <= compare_a_value[15:8];
        OFS_COMPARE_P_TOP: rdata_o <= compare_p_value;
        OFS_MATCH_STATUS: rdata_o <= {6'h00, compare_p_flag, compare_a_flag};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  assign on_rise = ctrl_a.counter_on & ~on_last;
  // pause keeps the count without a clear; off does the same, see below
  assign running = ctrl_a.counter_on & ~ctrl_a.pause_control
                   & count_tick;
  assign count_inc = {1'b0, count} + 17'h00001;
  assign overflow = count_inc[16];

  // compare a never fires at zero: that case is a plain overflow
  assign a_match = running && compare_a_value != 16'h0000
                   && count_inc[15:0] == compare_a_value;
  assign p_match = running && compare_p_value != 8'h00
                   && count_inc[15:0] == {compare_p_value, 8'h00};

  always_comb
  begin
    a_event = a_match;
    p_event = p_match || (running && overflow
                          && compare_p_value == 8'h00);
    if (ctrl_b.mode_select == MODE_PWM)
    begin
      if (ctrl_b.duty_period_swap)
        clear_now = a_match;
      else
        clear_now = p_match;
    end
    else
    begin
      if (ctrl_b.clear_source_select)
      begin
        clear_now = a_match;
        p_event = 1'b0;
      end
      else
        clear_now = p_match;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      on_last <= 1'b0;
    else
      on_last <= ctrl_a.counter_on;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count <= RST_COUNT;
    else if (on_rise)
      count <= 16'h0000;
    else if (clear_now)
      count <= 16'h0000;
    else if (running)
      count <= count_inc[15:0];
  end

  // ----------------------------------------------------------------------
  // match flags
  // ----------------------------------------------------------------------
  // a match in the cycle of a clear keeps the flag set
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end
    else
    begin
      if (a_event)
        compare_a_flag <= 1'b1;
      else if (clr_a_flag)
        compare_a_flag <= 1'b0;
      if (p_event)
        compare_p_flag <= 1'b1;
      else if (clr_p_flag)
        compare_p_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (ctrl_b.duty_period_swap)
      pwm_active = count[15:8] < compare_p_value
                   || compare_p_value == 8'h00;
    else
      pwm_active = count < compare_a_value;
  end

  // compare mode level lives in pin_level; pwm level is derived each cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_level <= 1'b0;
    else if (on_rise)
      pin_level <= ctrl_b.output_init_level;
    else if (ctrl_b.mode_select == MODE_COMPARE && a_match)
    begin
      unique case (ctrl_b.pin_action_select)
        ACT_NONE: pin_level <= pin_level;
        ACT_LOW: pin_level <= 1'b0;
        ACT_HIGH: pin_level <= 1'b1;
        ACT_TOGGLE: pin_level <= ~pin_level;
      endcase
    end
  end

  always_comb
  begin
    next_pin_level = 1'b0;
    unique case (ctrl_b.mode_select)
      MODE_COMPARE: next_pin_level = pin_level;
      MODE_PWM:
      begin
        unique case (ctrl_b.pin_action_select)
          PWM_FORCE_ACTIVE: next_pin_level = ctrl_b.output_init_level;
          PWM_WAVE: next_pin_level = ~(pwm_active
                                       ^ ctrl_b.output_init_level);
          default: next_pin_level = ~ctrl_b.output_init_level;
        endcase
      end
      // timer mode leaves the pin unused; it rests low
      default: next_pin_level = 1'b0;
    endcase
    if (ctrl_b.mode_select != MODE_TIMER
        && ctrl_b.mode_select != MODE_UNDEF && ctrl_b.output_invert)
      next_pin_level = ~next_pin_level;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timer_output_pin_o <= 1'b0;
    else
      timer_output_pin_o <= next_pin_level;
  end

endmodule // compact_timer

// File: test/compact_timer_assertions.sv
// checker: port-level properties of the compact timer
module compact_timer_assertions
  import ctimer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire reg_req_t bus_req_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic external_count_pin_i,
  input wire logic sub_clock_i,
  input wire logic timer_output_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // shadows of the writable registers
  // ----------------------------------------------------------------------
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] sh_ah;
  logic [7:0] sh_p;
  logic [1:0] age;
  logic rd0;
  logic cfg_ok;
  assign rd0 = bus_req_i.rd;
  // pin settles two edges after a config write, age 3 leaves margin
  assign cfg_ok = (age == 2'h3) && sh_a[3];
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
      sh_ah <= 8'h00;
      sh_p <= 8'h00;
    end
    else if (bus_req_i.wr)
    begin
      if (bus_req_i.addr == OFS_TIMER_CONTROL_A) sh_a <= bus_req_i.wdata;
      if (bus_req_i.addr == OFS_TIMER_CONTROL_B) sh_b <= bus_req_i.wdata;
      if (bus_req_i.addr == OFS_COMPARE_A_HIGH) sh_ah <= bus_req_i.wdata;
      if (bus_req_i.addr == OFS_COMPARE_P_TOP) sh_p <= bus_req_i.wdata;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      age <= 2'h0;
    else if (bus_req_i.wr && bus_req_i.addr <= 3'h1)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_rd_idle;
    !rd0 |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_ctl_a;
    rd0 && bus_req_i.addr == 3'h0 |=> rdata_o == {sh_a[7:3], 3'h0};
  endproperty
  a_ctl_a: assert property (p_ctl_a)
    else $error("control a read back wrong");
  property p_ctl_b;
    rd0 && bus_req_i.addr == 3'h1 |=> rdata_o == sh_b;
  endproperty
  a_ctl_b: assert property (p_ctl_b)
    else $error("control b read back wrong");
  property p_cmp_a_hi;
    rd0 && bus_req_i.addr == 3'h5 |=> rdata_o == sh_ah;
  endproperty
  a_cmp_a_hi: assert property (p_cmp_a_hi)
    else $error("compare a high byte wrong");
  property p_cmp_p;
    rd0 && bus_req_i.addr == 3'h6 |=> rdata_o == sh_p;
  endproperty
  a_cmp_p: assert property (p_cmp_p)
    else $error("compare p byte wrong");
  property p_pwm_off;
    cfg_ok && sh_b[7:4] == 4'h8
      |-> timer_output_pin_o == (!sh_b[3] ^ sh_b[2]);
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("forced inactive pwm level wrong");
  property p_pwm_on;
    cfg_ok && sh_b[7:4] == 4'h9
      |-> timer_output_pin_o == (sh_b[3] ^ sh_b[2]);
  endproperty
  a_pwm_on: assert property (p_pwm_on)
    else $error("forced active pwm level wrong");
  property p_timer_pin;
    cfg_ok && sh_b[7:6] == 2'h3 |-> !timer_output_pin_o;
  endproperty
  a_timer_pin: assert property (p_timer_pin)
    else $error("pin driven in timer mode");
  c_cmp_read: cover property (rd0 && bus_req_i.addr == 3'h5);
  c_pwm_force: cover property (cfg_ok && sh_b[7:6] == 2'h2);
  c_timer: cover property (cfg_ok && sh_b[7:6] == 2'h3);
endmodule // compact_timer_assertions

bind compact_timer compact_timer_assertions u_compact_timer_assertions (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .bus_req_i(bus_req_i),
  .rdata_o(rdata_o),
  .external_count_pin_i(external_count_pin_i),
  .sub_clock_i(sub_clock_i),
  .timer_output_pin_o(timer_output_pin_o)
);

// File: test/testbench.sv
// testbench: register and count-pin stimulus for the compact timer
module testbench
  import ctimer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t bus_req = '0;
  logic ext_pin = 1'b0;
  logic sub_clk = 1'b0;
  logic sub_sel = 1'b0;
  // divider of each internal count source, by select code
  int div_of[4] = '{4, 1, 16, 64};
  logic [7:0] rdata;
  logic pin;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] rd_q[$];
  logic pin_q[$];
  logic rd_seen = 1'b0;
  logic pin_due = 1'b0;
  always #25 clk_sys = ~clk_sys;
  compact_timer u_compact_timer (
    .clk_sys_i(clk_sys),
    .arst_n_i(arst_n),
    .bus_req_i(bus_req),
    .rdata_o(rdata),
    .external_count_pin_i(ext_pin),
    .sub_clock_i(sub_clk),
    .timer_output_pin_o(pin)
  );
  // ----------------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("MISMATCH rdata expected %h seen %h", e, s);
      err_count++;
    end
  endtask
  task automatic cmp_pin(input logic e, input logic s);
    check_count++;
    if (s !== e)
    begin
      $display("MISMATCH pin expected %b seen %b", e, s);
      err_count++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (rd_seen)
      cmp_byte(rd_q.pop_front(), rdata);
    if (pin_due)
      cmp_pin(pin_q.pop_front(), pin);
    rd_seen <= bus_req.rd;
  end
  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= {a, d, 2'b10};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys);
    bus_req <= {a, 8'h00, 2'b01};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  // high byte first, so the low byte comes from the captured buffer
  task automatic read16(input logic [15:0] e);
    rd(OFS_COUNT_HIGH, e[15:8]);
    rd(OFS_COUNT_LOW, e[7:0]);
  endtask
  task automatic exp_pin(input logic e);
    pin_q.push_back(e);
    @(posedge clk_sys);
    pin_due <= 1'b1;
    @(posedge clk_sys);
    pin_due <= 1'b0;
  endtask
  // slow pulses leave room for the two-flop synchroniser
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      {sub_clk, ext_pin} <= sub_sel ? 2'b10 : 2'b01;
      repeat (2) @(posedge clk_sys);
      {sub_clk, ext_pin} <= 2'b00;
      repeat (2) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [15:0] n;
    logic [7:0] b;
    logic e;
    n = 16'($urandom(90607));
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[2:0], 8'h00);
    wr(OFS_COUNT_LOW, 8'h5a);
    wr(OFS_COUNT_HIGH, 8'ha5);
    read16(16'h0000);
    wr(OFS_TIMER_CONTROL_A, 8'hff);
    rd(OFS_TIMER_CONTROL_A, 8'hf8);
    wr(OFS_TIMER_CONTROL_A, 8'h00);
    b = 8'($urandom);
    wr(OFS_TIMER_CONTROL_B, b);
    rd(OFS_TIMER_CONTROL_B, b);
    wr(OFS_TIMER_CONTROL_B, 8'h00);
    wr(OFS_COMPARE_A_LOW, 8'h34);
    wr(OFS_COMPARE_A_HIGH, 8'h12);
    rd(OFS_COMPARE_A_HIGH, 8'h12);
    rd(OFS_COMPARE_A_LOW, 8'h34);
    n = 16'(3 + $urandom % 10);
    wr(OFS_TIMER_CONTROL_A, 8'h68);
    pulse(n);
    read16(n);
    wr(OFS_TIMER_CONTROL_A, 8'he8);
    pulse(3);
    read16(n);
    wr(OFS_TIMER_CONTROL_A, 8'h78);
    pulse(2);
    read16(n + 16'h2);
    wr(OFS_TIMER_CONTROL_A, 8'h70);
    pulse(3);
    read16(n + 16'h2);
    wr(OFS_TIMER_CONTROL_A, 8'h68);
    pulse(1);
    read16(16'h0001);
    wr(OFS_TIMER_CONTROL_A, 8'h60);
    // internal sources: the run spans n divider periods, sub sources n pulses,
    // plus the clearing cycle after switch-on
    for (int s = 0; s < 6; s++)
    begin
      n = 16'(1 + $urandom % 4);
      sub_sel = s > 3;
      wr(OFS_TIMER_CONTROL_A, {1'b0, s[2:0], 4'h8});
      if (s > 3)
        pulse(n);
      else
        repeat (n * div_of[s] - 1) @(posedge clk_sys);
      wr(OFS_TIMER_CONTROL_A, {1'b0, s[2:0], 4'h0});
      read16(n);
    end
    sub_sel = 1'b0;
    wr(OFS_COMPARE_A_LOW, 8'h04);
    wr(OFS_COMPARE_A_HIGH, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_TIMER_CONTROL_B, {2'h0, i[1:0], i[2], i[2] ^ i[0], 2'h1});
      wr(OFS_TIMER_CONTROL_A, 8'h68);
      n = 16'(5 + $urandom % 8);
      pulse(n);
      read16(n % 16'h4);
      rd(OFS_MATCH_STATUS, 8'h01);
      case (i[1:0])
        2'h0: e = i[2];
        2'h1: e = 1'b0;
        2'h2: e = 1'b1;
        default: e = i[2] ^ n[2];
      endcase
      exp_pin(e ^ i[2] ^ i[0]);
      wr(OFS_MATCH_STATUS, 8'h03);
      wr(OFS_TIMER_CONTROL_A, 8'h60);
    end
    wr(OFS_COMPARE_A_LOW, 8'h00);
    wr(OFS_COMPARE_A_HIGH, 8'h00);
    wr(OFS_COMPARE_P_TOP, 8'h01);
    wr(OFS_TIMER_CONTROL_B, 8'h00);
    wr(OFS_TIMER_CONTROL_A, 8'h68);
    pulse(259);
    read16(16'h0003);
    rd(OFS_MATCH_STATUS, 8'h02);
    wr(OFS_TIMER_CONTROL_A, 8'h60);
    // pwm wave: sampled early in the period and well past the duty point
    for (int x = 0; x < 2; x++)
    begin
      wr(OFS_COMPARE_A_LOW, x ? 8'h00 : 8'h40);
      wr(OFS_COMPARE_A_HIGH, x ? 8'h02 : 8'h00);
      wr(OFS_TIMER_CONTROL_B, {2'h2, 2'h2, 1'b1, 1'b0, x[0], 1'b0});
      wr(OFS_TIMER_CONTROL_A, 8'h18);
      repeat (11) @(posedge clk_sys);
      exp_pin(1'b1);
      repeat (x ? 288 : 100) @(posedge clk_sys);
      exp_pin(1'b0);
      wr(OFS_TIMER_CONTROL_A, 8'h10);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_TIMER_CONTROL_B, {2'h2, 1'b0, i[0], i[1], i[2], 2'h1});
      wr(OFS_TIMER_CONTROL_A, 8'h68);
      repeat (4) @(posedge clk_sys);
      exp_pin((i[0] ? i[1] : !i[1]) ^ i[2]);
      wr(OFS_TIMER_CONTROL_A, 8'h60);
    end
    wr(OFS_TIMER_CONTROL_B, 8'hcc);
    wr(OFS_TIMER_CONTROL_A, 8'h68);
    repeat (4) @(posedge clk_sys);
    exp_pin(1'b0);
    // let the last notes drain before the verdict
    repeat (3) @(posedge clk_sys);
    if (rd_q.size() != 0 || pin_q.size() != 0)
    begin
      $display("MISMATCH queue expected 0 seen %0d",
               rd_q.size() + pin_q.size());
      err_count++;
    end
    report_and_stop();
  end
endmodule // testbench
